// ### rtl/tcs_edge.sv
// Two-flop synchroniser with falling-edge pulse for one external input.
`timescale 1ns/1ps
module tcs_edge (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Asynchronous input.
  input wire logic i_pin,
  // Synchronised level and falling-edge pulse.
  output logic o_level,
  output logic o_fall
);
  logic meta_q; // First stage, read only by the second.
  logic sync_q; // Second stage.
  logic prev_q; // Previous synchronised sample.

  // Sample the pin twice, then keep one more sample for edge detection.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (i_ce) begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  // A high sample followed by a low one is one falling edge.
  assign o_fall = prev_q & ~sync_q;
endmodule

// ### rtl/tcs_pkg.sv
// Package of constants and types for the four-timer counter/timer set.
package tcs_pkg;

  // ************************************************************
  // Register map (word-aligned byte offsets)
  // ************************************************************
  localparam logic [7:0] TCS_OFF_CLKCTL = 8'h00; // Clock control.
  localparam logic [7:0] TCS_OFF_MODE = 8'h04; // Modes and run bits.
  localparam logic [7:0] TCS_OFF_T0 = 8'h08; // Timer zero count.
  localparam logic [7:0] TCS_OFF_T1 = 8'h0C; // Timer one count.
  localparam logic [7:0] TCS_OFF_T2 = 8'h10; // Timer two count.
  localparam logic [7:0] TCS_OFF_T3 = 8'h14; // Timer three count.
  localparam logic [7:0] TCS_OFF_R2 = 8'h18; // Timer two reload.
  localparam logic [7:0] TCS_OFF_R3 = 8'h1C; // Timer three reload.
  localparam logic [7:0] TCS_OFF_CAP = 8'h20; // Capture values, three over two.
  localparam logic [7:0] TCS_OFF_STAT = 8'h24; // Sticky event status.
  localparam logic [7:0] TCS_OFF_MASK = 8'h28; // Interrupt mask.

  // ************************************************************
  // Field positions of the clock control word
  // ************************************************************
  localparam int TCS_CK_PRESCALE = 0; // Two-bit prescale select.
  localparam int TCS_CK_T0SEL = 2; // Timer zero system-clock select.
  localparam int TCS_CK_T1SEL = 3; // Timer one system-clock select.
  localparam int TCS_CK_T2SRC = 4; // Timer two source, two bits.
  localparam int TCS_CK_T3SRC = 6; // Timer three source, two bits.

  // ************************************************************
  // Field positions of the mode word
  // ************************************************************
  localparam int TCS_MD_T0MODE = 0; // Timer zero mode, two bits.
  localparam int TCS_MD_T0CNT = 2; // Timer zero counts pin edges.
  localparam int TCS_MD_T1MODE = 4; // Timer one mode, two bits.
  localparam int TCS_MD_T1CNT = 6; // Timer one counts pin edges.
  localparam int TCS_MD_RUN = 8; // Four run bits.
  localparam int TCS_MD_SPLIT = 12; // Split bits of timers two and three.
  localparam int TCS_MD_CAPT = 14; // Capture bits of timers two and three.

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [31:0] TCS_RST_WORD = 32'h0000_0000; // All registers clear.
  localparam int TCS_DIV4 = 4; // Prescale divide by four.
  localparam int TCS_DIV8 = 8; // External source divide by eight.
  localparam int TCS_DIV12 = 12; // System clock divide by twelve.
  localparam int TCS_DIV48 = 48; // System clock divide by forty-eight.

  // Classic timer modes.
  typedef enum logic [1:0] {
    TCS_M13 = 2'b00,
    TCS_M16 = 2'b01,
    TCS_M8R = 2'b10,
    TCS_MSPLIT = 2'b11
  } tcs_mode_e;

  // Auto-reload timer clock sources.
  typedef enum logic [1:0] {
    TCS_SRC_DIV12 = 2'b00,
    TCS_SRC_SYS = 2'b01,
    TCS_SRC_DIV8 = 2'b10,
    TCS_SRC_CMP = 2'b11
  } tcs_src_e;

  // External inputs from pins and slow oscillators.
  typedef struct packed {
    logic timer_zero_event_input;
    logic timer_one_event_input;
    logic ext_clk;
    logic rtc_clk;
    logic cmp0;
    logic cmp1;
  } tcs_pins_s;

endpackage

// ### rtl/tcs_top.sv
// Four 16-bit counter/timers with an AXI4-Lite register slave.
`timescale 1ns/1ps
module tcs_top (
  // Clock, reset and enable.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Pins and slow clock sources.
  input wire tcs_pkg::tcs_pins_s i_pins,
  // AXI4-Lite write address.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response.
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read address.
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // AXI4-Lite read data.
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Interrupt.
  output logic o_irq
);
  import tcs_pkg::*;

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] clkctl_q; // Clock control word.
  logic [15:0] mode_q; // Mode word.
  logic [15:0] cnt_q [4]; // Four counts.
  logic [15:0] rel_q [2]; // Reload values of timers two and three.
  logic [15:0] cap_q [2]; // Captured counts of timers two and three.
  logic [5:0] stat_q; // Sticky flags: ovf0, ovf1, ovf2, ovf3, ovf0h, reserved..
  logic [5:0] mask_q; // Interrupt mask.
  logic [5:0] evt; // Event pulses this cycle.

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [5:0] pin_vec; // Raw inputs.
  logic [5:0] pin_fall; // Falling-edge pulses.
  logic [5:0] pin_lvl; // Synchronised levels, unused beyond edges.
  assign pin_vec = {i_pins.timer_zero_event_input, i_pins.timer_one_event_input,
                    i_pins.ext_clk, i_pins.rtc_clk, i_pins.cmp0, i_pins.cmp1};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      tcs_edge u_edge (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(pin_vec[gi]),
        .o_level(pin_lvl[gi]),
        .o_fall(pin_fall[gi])
      );
    end
  endgenerate

  logic t0_fall, t1_fall, ext_fall, rtc_fall, c0_fall, c1_fall;
  assign {t0_fall, t1_fall, ext_fall, rtc_fall, c0_fall, c1_fall} = pin_fall;

  // ************************************************************
  // Prescalers
  // ************************************************************
  logic [5:0] div_q; // Shared divider up to forty-eight.
  logic [2:0] ext8_q; // External divide by eight.
  logic [2:0] rtc8_q; // RTC divide by eight.
  logic [3:0] d12_q; // Divide by twelve for reload timers.

  // Dividers: div_q and d12_q run freely, ext8_q and rtc8_q count pin falling edges; each yields a one-cycle tick.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= 6'h00;
      ext8_q <= 3'h0;
      rtc8_q <= 3'h0;
      d12_q <= 4'h0;
    end else if (i_ce) begin
      div_q <= (div_q == 6'(TCS_DIV48 - 1)) ? 6'h00 : div_q + 6'h01;
      d12_q <= (d12_q == 4'(TCS_DIV12 - 1)) ? 4'h0 : d12_q + 4'h1;
      if (ext_fall) begin
        ext8_q <= ext8_q + 3'h1;
      end
      if (rtc_fall) begin
        rtc8_q <= rtc8_q + 3'h1;
      end
    end
  end

  logic tick12, tick4, tick48, ext_tick8, rtc_tick8, presc_tick;
  // Ticks fire on the last phase of each divider.
  assign tick48 = (div_q == 6'(TCS_DIV48 - 1));
  assign tick12 = (d12_q == 4'(TCS_DIV12 - 1));
  assign tick4 = (div_q[1:0] == 2'(TCS_DIV4 - 1));
  assign ext_tick8 = ext_fall && (ext8_q == 3'(TCS_DIV8 - 1));
  assign rtc_tick8 = rtc_fall && (rtc8_q == 3'(TCS_DIV8 - 1));

  // Shared prescale select.
  always_comb begin
    case (clkctl_q[TCS_CK_PRESCALE +: 2])
      2'b00: presc_tick = tick12;
      2'b01: presc_tick = tick4;
      2'b10: presc_tick = tick48;
      default: presc_tick = ext_tick8;
    endcase
  end

  // Classic timer increment: pin edge when counting, else clock select.
  function automatic logic classic_inc(input logic cnt_mode, input logic sys_sel,
                                       input logic fall, input logic ptick);
    if (cnt_mode) begin
      return fall;
    end else begin
      return sys_sel ? 1'b1 : ptick;
    end
  endfunction

  // Reload timer increment by source select.
  function automatic logic reload_inc(input logic [1:0] src, input logic t12,
                                      input logic t8, input logic cf);
    case (tcs_src_e'(src))
      TCS_SRC_DIV12: return t12;
      TCS_SRC_SYS: return 1'b1;
      TCS_SRC_DIV8: return t8;
      default: return cf;
    endcase
  endfunction

  logic inc0, inc1, inc2, inc3;
  assign inc0 = mode_q[TCS_MD_RUN] & classic_inc(mode_q[TCS_MD_T0CNT], clkctl_q[TCS_CK_T0SEL], t0_fall, presc_tick);
  assign inc1 = mode_q[TCS_MD_RUN + 1] &
                classic_inc(mode_q[TCS_MD_T1CNT], clkctl_q[TCS_CK_T1SEL], t1_fall, presc_tick);
  assign inc2 = reload_inc(clkctl_q[TCS_CK_T2SRC +: 2], tick12, rtc_tick8, c0_fall);
  assign inc3 = reload_inc(clkctl_q[TCS_CK_T3SRC +: 2], tick12, ext_tick8, c1_fall);

  // ************************************************************
  // Bus handshake state
  // ************************************************************
  logic aw_hold_q, w_hold_q; // Accepted write halves.
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go; // Both halves present and no response pending: perform the write.
  assign wr_go = aw_hold_q && w_hold_q && !o_bvalid;

  // Byte-lane merge of a write into an old value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction

  logic [31:0] wmerged_clk, wmerged_mode;
  assign wmerged_clk = merge({24'h00_0000, clkctl_q}, wdata_q, wstrb_q);
  assign wmerged_mode = merge({16'h0000, mode_q}, wdata_q, wstrb_q);

  // Write address and data channels, taken independently.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= TCS_RST_WORD;
      wstrb_q <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
    end else if (i_ce) begin
      o_awready <= !aw_hold_q && !o_awready;
      o_wready <= !w_hold_q && !o_wready;
      if (i_awvalid && o_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        o_bvalid <= 1'b1;
        // Unmapped addresses answer with a slave error.
        o_bresp <= (awaddr_q > TCS_OFF_MASK || awaddr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Configuration and interrupt mask registers.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clkctl_q <= TCS_RST_WORD[7:0];
      mode_q <= TCS_RST_WORD[15:0];
      mask_q <= TCS_RST_WORD[5:0];
      rel_q[0] <= TCS_RST_WORD[15:0];
      rel_q[1] <= TCS_RST_WORD[15:0];
    end else if (i_ce && wr_go) begin
      if (awaddr_q == TCS_OFF_CLKCTL) begin
        clkctl_q <= wmerged_clk[7:0];
      end else if (awaddr_q == TCS_OFF_MODE) begin
        mode_q <= wmerged_mode[15:0];
      end else if (awaddr_q == TCS_OFF_MASK) begin
        mask_q <= wdata_q[5:0];
      end else if (awaddr_q == TCS_OFF_R2) begin
        rel_q[0] <= wdata_q[15:0];
      end else if (awaddr_q == TCS_OFF_R3) begin
        rel_q[1] <= wdata_q[15:0];
      end
    end
  end

  // ************************************************************
  // Classic timers
  // ************************************************************
  tcs_mode_e md0, md1;
  assign md0 = tcs_mode_e'(mode_q[TCS_MD_T0MODE +: 2]);
  assign md1 = tcs_mode_e'(mode_q[TCS_MD_T1MODE +: 2]);
  logic wr_t0, wr_t1, wr_t2, wr_t3;
  assign wr_t0 = wr_go && awaddr_q == TCS_OFF_T0;
  assign wr_t1 = wr_go && awaddr_q == TCS_OFF_T1;
  assign wr_t2 = wr_go && awaddr_q == TCS_OFF_T2;
  assign wr_t3 = wr_go && awaddr_q == TCS_OFF_T3;

  // Timer zero: all four modes; split high byte runs on the timer-one run bit.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q[0] <= TCS_RST_WORD[15:0];
      evt[0] <= 1'b0;
      evt[4] <= 1'b0;
    end else if (i_ce) begin
      evt[0] <= 1'b0;
      evt[4] <= 1'b0;
      if (wr_t0) begin
        cnt_q[0] <= wdata_q[15:0];
      end else begin
        case (md0)
          TCS_M13: if (inc0) begin
            // Five low bits then eight high bits; wrap at all ones.
            cnt_q[0] <= {cnt_q[0][15:8] + {7'h00, &cnt_q[0][4:0]}, 3'b000, cnt_q[0][4:0] + 5'h01};
            evt[0] <= (&cnt_q[0][15:8]) && (&cnt_q[0][4:0]);
          end
          TCS_M16: if (inc0) begin
            cnt_q[0] <= cnt_q[0] + 16'h0001;
            evt[0] <= &cnt_q[0];
          end
          TCS_M8R: if (inc0) begin
            cnt_q[0][7:0] <= (&cnt_q[0][7:0]) ? cnt_q[0][15:8] : cnt_q[0][7:0] + 8'h01;
            evt[0] <= &cnt_q[0][7:0];
          end
          default: begin
            if (inc0) begin
              cnt_q[0][7:0] <= cnt_q[0][7:0] + 8'h01;
              evt[0] <= &cnt_q[0][7:0];
            end
            // High byte counts the system clock or the shared prescale tick on timer one's run bit.
            if (mode_q[TCS_MD_RUN + 1] && (clkctl_q[TCS_CK_T0SEL] || presc_tick)) begin
              cnt_q[0][15:8] <= cnt_q[0][15:8] + 8'h01;
              evt[4] <= &cnt_q[0][15:8];
            end
          end
        endcase
      end
    end
  end

  // Timer one: split mode holds the count still.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q[1] <= TCS_RST_WORD[15:0];
      evt[1] <= 1'b0;
      evt[5] <= 1'b0;
    end else if (i_ce) begin
      evt[1] <= 1'b0;
      // The reserved status bit never sees an event.
      evt[5] <= 1'b0;
      if (wr_t1) begin
        cnt_q[1] <= wdata_q[15:0];
      end else if (inc1 && md1 == TCS_M13) begin
        cnt_q[1] <= {cnt_q[1][15:8] + {7'h00, &cnt_q[1][4:0]}, 3'b000, cnt_q[1][4:0] + 5'h01};
        evt[1] <= (&cnt_q[1][15:8]) && (&cnt_q[1][4:0]);
      end else if (inc1 && md1 == TCS_M16) begin
        cnt_q[1] <= cnt_q[1] + 16'h0001;
        evt[1] <= &cnt_q[1];
      end else if (inc1 && md1 == TCS_M8R) begin
        cnt_q[1][7:0] <= (&cnt_q[1][7:0]) ? cnt_q[1][15:8] : cnt_q[1][7:0] + 8'h01;
        evt[1] <= &cnt_q[1][7:0];
      end
    end
  end

  // ************************************************************
  // Auto-reload timers
  // ************************************************************
  logic [1:0] inc_r, wr_r;
  logic [1:0] cap_src;
  assign inc_r = {inc3, inc2};
  assign wr_r = {wr_t3, wr_t2};
  // Capture is triggered by the slow source edge; count runs on system or /12.
  assign cap_src = {c1_fall | ext_tick8, c0_fall | rtc_tick8};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_reload
      logic run, split, capt, tick;
      assign run = mode_q[TCS_MD_RUN + 2 + gi];
      assign split = mode_q[TCS_MD_SPLIT + gi];
      assign capt = mode_q[TCS_MD_CAPT + gi];
      // In capture mode the counter runs on the system clock or divide-twelve.
      assign tick = capt ? (clkctl_q[TCS_CK_T2SRC + 2*gi] | tick12) : inc_r[gi];

      // One timer: 16-bit reload, two 8-bit reloads, or capture.
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          cnt_q[2 + gi] <= TCS_RST_WORD[15:0];
          cap_q[gi] <= TCS_RST_WORD[15:0];
          evt[2 + gi] <= 1'b0;
        end else if (i_ce) begin
          evt[2 + gi] <= 1'b0;
          if (wr_r[gi]) begin
            cnt_q[2 + gi] <= wdata_q[15:0];
          end else if (run && capt && cap_src[gi]) begin
            // Latch the count of the fast clock over one slow period.
            cap_q[gi] <= cnt_q[2 + gi];
            cnt_q[2 + gi] <= 16'h0000;
            evt[2 + gi] <= 1'b1;
          end else if (run && tick && split) begin
            cnt_q[2 + gi][7:0] <= (&cnt_q[2 + gi][7:0]) ? rel_q[gi][7:0] : cnt_q[2 + gi][7:0] + 8'h01;
            cnt_q[2 + gi][15:8] <= (&cnt_q[2 + gi][15:8]) ? rel_q[gi][15:8] : cnt_q[2 + gi][15:8] + 8'h01;
            evt[2 + gi] <= &cnt_q[2 + gi][15:8];
          end else if (run && tick) begin
            cnt_q[2 + gi] <= (&cnt_q[2 + gi]) ? rel_q[gi] : cnt_q[2 + gi] + 16'h0001;
            evt[2 + gi] <= &cnt_q[2 + gi];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Status and interrupt
  // ************************************************************
  logic [5:0] clr;
  assign clr = (wr_go && awaddr_q == TCS_OFF_STAT) ? wdata_q[5:0] : 6'h00;

  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_q <= TCS_RST_WORD[5:0];
      o_irq <= 1'b0;
    end else if (i_ce) begin
      stat_q <= (stat_q & ~clr) | evt;
      o_irq <= |(((stat_q & ~clr) | evt) & mask_q);
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [31:0] rd_word;
  always_comb begin
    if (i_araddr == TCS_OFF_CLKCTL) begin
      rd_word = {24'h00_0000, clkctl_q};
    end else if (i_araddr == TCS_OFF_MODE) begin
      rd_word = {16'h0000, mode_q};
    end else if (i_araddr == TCS_OFF_T0) begin
      rd_word = {16'h0000, cnt_q[0]};
    end else if (i_araddr == TCS_OFF_T1) begin
      rd_word = {16'h0000, cnt_q[1]};
    end else if (i_araddr == TCS_OFF_T2) begin
      rd_word = {16'h0000, cnt_q[2]};
    end else if (i_araddr == TCS_OFF_T3) begin
      rd_word = {16'h0000, cnt_q[3]};
    end else if (i_araddr == TCS_OFF_R2) begin
      rd_word = {16'h0000, rel_q[0]};
    end else if (i_araddr == TCS_OFF_R3) begin
      rd_word = {16'h0000, rel_q[1]};
    end else if (i_araddr == TCS_OFF_CAP) begin
      rd_word = {cap_q[1], cap_q[0]};
    end else if (i_araddr == TCS_OFF_STAT) begin
      rd_word = {26'h000_0000, stat_q};
    end else if (i_araddr == TCS_OFF_MASK) begin
      rd_word = {26'h000_0000, mask_q};
    end else begin
      rd_word = 32'hDEAD_0000;
    end
  end

  // One read at a time; data sampled when the address is taken.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= TCS_RST_WORD;
      o_rresp <= 2'b00;
    end else if (i_ce) begin
      o_arready <= !o_rvalid && !o_arready && i_arvalid;
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= (rd_word == 32'hDEAD_0000) ? 2'b10 : 2'b00;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### sim/tcs_checker.sv
// Bus handshake assertions for the counter/timer set.
`timescale 1ns/1ps
module tcs_checker (
  // Clock, reset and enable.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Bus inputs.
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic i_rready,
  // Bus outputs.
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp
);
  // ************************************************************
  // Register access answers.
  // ************************************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (i_ce && i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (i_ce && i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write answer late");
  a_aw_once: assert property (i_ce && i_awvalid && o_awready |=> !o_awready)
    else $error("address taken twice");
  a_ar_cause: assert property ($rose(o_arready) |-> $past(i_arvalid))
    else $error("read ready without request");
  a_ar_busy: assert property (o_rvalid |-> !o_arready)
    else $error("read ready while answer pending");
  a_rresp_code: assert property (o_rvalid |-> o_rresp == 2'b00 || o_rresp == 2'b10)
    else $error("bad read response code");
endmodule
bind tcs_top tcs_checker chk_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
  .i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .o_bresp(o_bresp), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp));

// ### sim/tcs_pin_model.sv
// Pulse source standing in for the event pins and slow clocks.
`timescale 1ns/1ps
module tcs_pin_model (
  // Clock and command.
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [7:0] i_num,
  input wire logic [3:0] i_half,
  input wire logic [5:0] i_sel,
  // Pin levels and activity.
  output tcs_pkg::tcs_pins_s o_pins,
  output logic o_busy
);
  import tcs_pkg::*;
  logic [8:0] left_q = 9'h000; // Level changes still to make; two per falling edge.
  logic [3:0] ph_q = 4'h0; // Cycles spent at the present level.
  logic lvl_q = 1'b1; // Level starts and ends high, so idle pins never fall.
  // Each level is held i_half cycles, two or more.
  always @(posedge i_ref_clk) begin
    if (i_go) begin
      left_q <= {i_num, 1'b0};
      ph_q <= 4'h0;
    end else if (left_q != 9'h000) begin
      ph_q <= (ph_q == i_half - 4'h1) ? 4'h0 : ph_q + 4'h1;
      if (ph_q == i_half - 4'h1) begin
        lvl_q <= !lvl_q;
        left_q <= left_q - 9'h001;
      end
    end
  end
  assign o_pins = lvl_q ? 6'h3F : ~i_sel;
  assign o_busy = (left_q != 9'h000);
endmodule

// ### sim/test_tcs_top.sv
// Register-level test bench of the counter/timer set.
`timescale 1ns/1ps
module test_tcs_top;
  import tcs_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, go = 1'b0, busy;
  logic [7:0] num = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [5:0] sel = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, r;
  tcs_pins_s pins;
  int n_fail = 0, checks_done = 0;
  logic [31:0] ctl [6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0008, 32'h0000_0000, 32'h0000_0010};
  logic [31:0] md [6] = '{32'h0000_0210, 32'h0000_0210, 32'h0000_0210, 32'h0000_0210, 32'h0000_0400, 32'h0000_0400};
  logic [7:0] cof [6] = '{TCS_OFF_T1, TCS_OFF_T1, TCS_OFF_T1, TCS_OFF_T1, TCS_OFF_T2, TCS_OFF_T2};
  int dv [6] = '{12, 4, 48, 1, 12, 1};
  always #2 clk = ~clk;
  tcs_pin_model pm_u (.i_ref_clk(clk), .i_go(go), .i_num(num), .i_half(4'h2), .i_sel(sel), .o_pins(pins),
    .o_busy(busy));
  tcs_top dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_pins(pins), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_irq(irq));
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that ran out of its bound ends the run.
  task automatic lost(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      test_done();
    end
  endtask
  // Writes one word and waits for its response.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      got = bvalid && bready;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
    lost(n, 50);
  endtask
  // Reads one word with its response code.
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rc);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 50) begin
      @(posedge clk);
      n++;
      got = rvalid;
      v = rdata;
      rc = rresp;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
    lost(n, 50);
  endtask
  // Makes k falling edges on the selected pins at a quarter of the clock rate.
  task automatic fire(input logic [7:0] k, input logic [5:0] s);
    int n;
    n = 0;
    num <= k;
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy && n < 900) begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    lost(n, 900);
  endtask
  // Stops a hung run.
  initial begin
    repeat (100000) @(posedge clk);
    lost(1, 1);
  end
  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4), d, r);
      chk("reset word", TCS_RST_WORD, d);
    end
    rd(8'h30, d, r);
    chk("unmapped data", 32'hDEAD_0000, d);
    chk("unmapped resp", 32'h0000_0002, 32'(r));
    $display("test reset done");
    wr(TCS_OFF_CLKCTL, 32'h0000_0004);
    wr(TCS_OFF_MODE, 32'h0000_0105);
    fire(8'h0A, 6'h20);
    rd(TCS_OFF_T0, d, r);
    chk("pin count", 32'h0000_000A, d);
    $display("test counting done");
    wr(TCS_OFF_MODE, 32'h0000_0104);
    wr(TCS_OFF_T0, 32'h0000_FFFF);
    fire(8'h01, 6'h20);
    rd(TCS_OFF_STAT, d, r);
    chk("wrap flag", 32'h0000_0001, d & 32'h0000_0001);
    chk("irq masked", 32'h0000_0000, 32'(irq));
    wr(TCS_OFF_MASK, 32'h0000_0001);
    chk("irq raised", 32'h0000_0001, 32'(irq));
    wr(TCS_OFF_STAT, 32'h0000_0001);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    $display("test interrupt done");
    for (int i = 0; i < 6; i++) begin
      wr(TCS_OFF_MODE, 32'h0000_0000);
      wr(TCS_OFF_CLKCTL, ctl[i]);
      wr(cof[i], 32'h0000_0000);
      wr(TCS_OFF_MODE, md[i]);
      repeat (480) @(posedge clk);
      wr(TCS_OFF_MODE, 32'h0000_0000);
      rd(cof[i], d, r);
      chk("tick rate", 32'h0000_0001, 32'(d >= 480 / dv[i] - 1 && d <= 500 / dv[i] + 1));
    end
    wr(TCS_OFF_CLKCTL, 32'h0000_0003);
    wr(TCS_OFF_T1, 32'h0000_0000);
    wr(TCS_OFF_MODE, 32'h0000_0210);
    fire(8'h50, 6'h08);
    wr(TCS_OFF_MODE, 32'h0000_0000);
    rd(TCS_OFF_T1, d, r);
    chk("external rate", 32'h0000_0001, 32'(d >= 9 && d <= 11));
    $display("test clock sources done");
    test_done();
  end
endmodule
